// ### sim/rjd_prog_mem.sv
`timescale 1ns/1ps
module rjd_prog_mem
    import rjd_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              load,
    input  wire logic [PC_W-1:0]   load_addr,
    input  wire logic [INSN_W-1:0] load_word,
    input  wire logic [PC_W-1:0]   fetch_addr,
    output logic      [INSN_W-1:0] fetch_word
);
    // Small window of word storage; the bench loads a word just before fetching it
    logic [INSN_W-1:0] mem [256];

    always_ff @(posedge core_clk)
    begin
        if (load)
            mem[load_addr[8:1]] <= load_word;
    end

    assign fetch_word = mem[fetch_addr[8:1]];
endmodule

// ### sim/test_relative_jump_and_opcode_decode.sv
`timescale 1ns/1ps
module test_relative_jump_and_opcode_decode
    import rjd_pkg::*;
;
    logic              core_clk        = 1'b0;
    logic              resetn          = 1'b0;
    logic [ADDR_W-1:0] avs_address     = '0;
    logic              avs_read        = 1'b0;
    logic              avs_write       = 1'b0;
    logic [DATA_W-1:0] avs_writedata   = '0;
    logic [3:0]        avs_byteenable  = 4'hF;
    logic [DATA_W-1:0] avs_readdata;
    logic              avs_waitrequest;
    logic [PC_W-1:0]   program_counter;
    logic              global_interrupt_enable;
    logic              processor_halt;
    logic              oscillator_stop;
    logic              load            = 1'b0;
    logic [PC_W-1:0]   load_addr       = '0;
    logic [INSN_W-1:0] load_word       = '0;
    logic [INSN_W-1:0] fetch_word;
    logic [63:0]       expq [$];
    int                n_fail          = 0;
    int                samples_checked = 0;
    int                seed            = 32'hd6cc;
    int                stalls;

    rjd_core i_rjd_core (.core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .program_counter(program_counter), .global_interrupt_enable(global_interrupt_enable),
        .processor_halt(processor_halt), .oscillator_stop(oscillator_stop));

    rjd_prog_mem i_rjd_prog_mem (.core_clk(core_clk), .load(load), .load_addr(load_addr),
        .load_word(load_word), .fetch_addr(program_counter), .fetch_word(fetch_word));

    always #5 core_clk = ~core_clk;

    task automatic chk(input logic [31:0] exp, input logic [31:0] got, input logic [31:0] mask);
        samples_checked++;
        if ((got & mask) !== (exp & mask))
        begin
            n_fail++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Request stands until a rising edge samples waitrequest low; one idle edge then parts two transfers
    task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        stalls = 0;
        avs_address <= a;
        avs_write <= w;
        avs_read <= ~w;
        avs_writedata <= d;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0)
        begin
            stalls++;
            @(posedge core_clk);
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic [31:0] mask);
        expq.push_back({mask, exp});
        bus(1'b0, a, '0);
    endtask

    // Fetch through the program memory at the current counter, then hand the word to the core
    task automatic issue(input logic [INSN_W-1:0] w);
        load <= 1'b1;
        load_addr <= program_counter;
        load_word <= w;
        @(posedge core_clk);
        load <= 1'b0;
        @(posedge core_clk);
        bus(1'b1, ADDR_INSTR, 32'(fetch_word));
    endtask

    function automatic logic take(input logic [2:0] c, input logic [SR_W-1:0] s);
        case (c)
            COND_NONZERO:  return !s[SR_Z];
            COND_ZERO:     return s[SR_Z];
            COND_NO_CARRY: return !s[SR_C];
            COND_CARRY:    return s[SR_C];
            COND_NEGATIVE: return s[SR_N];
            COND_GE:       return !(s[SR_N] ^ s[SR_V]);
            COND_LESS:     return s[SR_N] ^ s[SR_V];
            default:       return 1'b1;
        endcase
    endfunction

    // Read data is taken at the very edge that accepts the read
    always @(posedge core_clk)
    begin : watch
        logic [63:0] note;
        if (avs_read && avs_waitrequest === 1'b0)
        begin
            if (expq.size() == 0)
                chk('0, '1, '1);
            else
            begin
                note = expq.pop_front();
                chk(note[31:0], avs_readdata, note[63:32]);
            end
        end
    end

    initial
    begin
        repeat (5000) @(posedge core_clk);
        n_fail++;
        wrap_up();
    end

    initial
    begin : main
        logic [SR_W-1:0]   sr;
        logic [PC_W-1:0]   pc;
        logic [PC_W-1:0]   np;
        logic [OFFS_W-1:0] off;
        logic              tk;
        logic [15:0]       single [10];
        logic [8:0]        wts [9];
        single = '{16'h1000, 16'h1040, 16'h1080, 16'h1100, 16'h1140, 16'h1180, 16'h1200, 16'h1240,
                   16'h1280, 16'h1300};
        wts = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h010, 9'h020, 9'h028, 9'h018, 9'h100};
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        rd(ADDR_INSTR, 32'(INSN_RESET), '1);
        rd(ADDR_PC, 32'(PC_RESET), '1);
        rd(ADDR_SR, 32'(SR_RESET), '1);
        rd(8'h10, '0, '1);
        bus(1'b1, ADDR_STATUS, '1);
        rd(ADDR_STATUS, '0, '1);
        $display("test reset and map done");
        for (int b = 0; b < 9; b++)
        begin
            bus(1'b1, ADDR_SR, 32'(wts[b]));
            rd(ADDR_SR, 32'(wts[b]), '1);
            chk(32'({wts[b][SR_OSC], wts[b][SR_HALT], wts[b][SR_GIE]}),
                32'({oscillator_stop, processor_halt, global_interrupt_enable}), '1);
        end
        $display("test status weights done");
        for (int i = 0; i < 40; i++)
        begin
            // Both reach extremes go through the unconditional code so they are always taken
            off = (i == 7) ? 10'h1FF : (i == 15) ? 10'h200 : 10'($random(seed));
            sr = 9'($random(seed));
            pc = 16'($random(seed)) & 16'hFFFE;
            tk = take(i[2:0], sr);
            np = pc + PC_STEP + (tk ? {{5{off[9]}}, off, 1'b0} : 16'h0000);
            bus(1'b1, ADDR_SR, 32'(sr));
            bus(1'b1, ADDR_PC, 32'(pc));
            issue({JUMP_PREFIX, i[2:0], off});
            rd(ADDR_STATUS, (32'(OP_JUMP) << ST_OP) | (32'(tk) << ST_TAKEN), '1);
            // The idle edge after the instruction write hides one of the busy cycles
            chk(32'(JUMP_CYCLES - 1), 32'(stalls), '1);
            rd(ADDR_PC, 32'(np), '1);
            chk(32'(np), 32'(program_counter), '1);
            rd(ADDR_SR, 32'(sr), '1);
        end
        $display("test relative jumps done");
        for (int k = 0; k < 22; k++)
        begin
            if (k < 10)
                issue(single[k] | 16'($random(seed) & 32'h0000_003F));
            else
                issue({4'(k - 6), 12'($random(seed))});
            rd(ADDR_STATUS, 32'(k < 10 ? k + 1 : k + 2) << ST_OP, 32'h0000_1F00);
            rd(ADDR_PC, 32'(np), '1);
        end
        $display("test opcode map done");
        wrap_up();
    end
endmodule

// ### verilog/rjd_cond.sv
`timescale 1ns/1ps
module rjd_cond
    import rjd_pkg::*;
(
    input  wire logic [2:0] cond_sel,
    input  wire rjd_flags_s flags,
    output logic            take
);

    always_comb
    begin
        case (cond_sel)
            COND_NONZERO:  take = ~flags.z;
            COND_ZERO:     take = flags.z;
            COND_NO_CARRY: take = ~flags.c;
            COND_CARRY:    take = flags.c;
            COND_NEGATIVE: take = flags.n;
            COND_GE:       take = ~(flags.n ^ flags.v);
            COND_LESS:     take = flags.n ^ flags.v;
            COND_ALWAYS:   take = 1'b1;
            default:       take = 1'b0;
        endcase
    end

endmodule

// ### verilog/rjd_core.sv
`timescale 1ns/1ps
module rjd_core
    import rjd_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [DATA_W-1:0] avs_writedata,
    input  wire logic [3:0]        avs_byteenable,
    output logic      [DATA_W-1:0] avs_readdata,
    output logic                   avs_waitrequest,
    output logic      [PC_W-1:0]   program_counter,
    output logic                   global_interrupt_enable,
    output logic                   processor_halt,
    output logic                   oscillator_stop
);

    rjd_state_s        st;
    rjd_state_s        next_st;
    rjd_flags_s        flags;
    logic              take;
    logic              is_jump;
    logic              idle;
    logic              start;
    logic [PC_W-1:0]   fall_through;
    logic [PC_W-1:0]   target;
    logic [DATA_W-1:0] merged_pc;
    logic [DATA_W-1:0] merged_sr;

    // Byte-lane merge of a bus write into a stored word
    function automatic logic [DATA_W-1:0] be_merge(input logic [DATA_W-1:0] old_v,
                                                   input logic [DATA_W-1:0] new_v,
                                                   input logic [3:0]        be);
        logic [DATA_W-1:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // Only basic encodings exist; composite forms arrive already as one of these
    function automatic rjd_op_e decode_op(input logic [INSN_W-1:0] insn);
        rjd_op_e op;
        op = OP_ILLEGAL;
        if (insn[15:13] == JUMP_PREFIX)
        begin
            op = OP_JUMP;
        end
        else if (insn[15:12] >= DOUBLE_FIRST)
        begin
            op = rjd_op_e'(DOUBLE_BASE + {1'b0, insn[15:12]});
        end
        else if (insn[15:10] == SINGLE_PREFIX)
        begin
            case (insn[9:6])
                4'h0:    op = OP_ROTATE_RIGHT_THROUGH_CARRY;
                4'h1:    op = OP_ROTATE_RIGHT_THROUGH_CARRY_B;
                4'h2:    op = OP_BYTE_SWAP;
                4'h4:    op = OP_ARITHMETIC_RIGHT_SHIFT;
                4'h5:    op = OP_ARITHMETIC_RIGHT_SHIFT_B;
                4'h6:    op = OP_SIGN_EXTEND;
                4'h8:    op = OP_PUSH;
                4'h9:    op = OP_PUSH_B;
                4'hA:    op = OP_CALL;
                4'hC:    op = OP_RETURN_FROM_INTERRUPT;
                default: op = OP_ILLEGAL;
            endcase
        end
        return op;
    endfunction

    assign flags     = '{v: st.sr[SR_V], n: st.sr[SR_N], z: st.sr[SR_Z], c: st.sr[SR_C]};
    assign is_jump   = (st.op == OP_JUMP);
    assign idle      = (st.fsm == RJD_IDLE);
    assign start     = idle && avs_write && (avs_address == ADDR_INSTR);
    assign merged_pc = be_merge({{(DATA_W-PC_W){1'b0}}, st.pc}, avs_writedata, avs_byteenable);
    assign merged_sr = be_merge({{(DATA_W-SR_W){1'b0}}, st.sr}, avs_writedata, avs_byteenable);

    rjd_cond u_cond (
        .cond_sel (st.instr[12:10]),
        .flags    (flags),
        .take     (take)
    );

    rjd_target #(
        .ADDR_BITS (PC_W)
    ) u_target (
        .pc_now       (st.pc),
        .offset       (st.instr[OFFS_W-1:0]),
        .fall_through (fall_through),
        .target       (target)
    );

    // Bus is held off while an instruction runs, so software never races the counter
    assign avs_waitrequest = (avs_read || avs_write) && !idle;

    always_comb
    begin
        next_st = st;
        case (st.fsm)
            RJD_IDLE:
            begin
                if (avs_write)
                begin
                    case (avs_address)
                        ADDR_INSTR:
                        begin
                            next_st.instr = avs_writedata[INSN_W-1:0];
                            next_st.op    = decode_op(avs_writedata[INSN_W-1:0]);
                            next_st.taken = 1'b0;
                            next_st.fsm   = RJD_EXEC;
                        end
                        ADDR_PC:
                        begin
                            next_st.pc = {merged_pc[PC_W-1:1], 1'b0};
                        end
                        ADDR_SR:
                        begin
                            next_st.sr = merged_sr[SR_W-1:0];
                        end
                        default:
                        begin
                            next_st.fsm = RJD_IDLE;
                        end
                    endcase
                end
            end
            RJD_EXEC:
            begin
                next_st.taken = is_jump && take;
                next_st.fsm   = RJD_RETIRE;
            end
            RJD_RETIRE:
            begin
                // Flags are left alone here on purpose
                if (is_jump)
                begin
                    next_st.pc = st.taken ? target : fall_through;
                end
                next_st.fsm = RJD_IDLE;
            end
            default:
            begin
                next_st.fsm = RJD_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st <= '{fsm: RJD_IDLE, instr: INSN_RESET, pc: PC_RESET, sr: SR_RESET,
                    taken: 1'b0, op: OP_ILLEGAL};
        end
        else
        begin
            st <= next_st;
        end
    end

    always_comb
    begin
        avs_readdata = '0;
        case (avs_address)
            ADDR_INSTR:  avs_readdata[INSN_W-1:0] = st.instr;
            ADDR_PC:     avs_readdata[PC_W-1:0]   = st.pc;
            ADDR_SR:     avs_readdata[SR_W-1:0]   = st.sr;
            ADDR_STATUS:
            begin
                avs_readdata[ST_BUSY]        = !idle;
                avs_readdata[ST_TAKEN]       = st.taken;
                avs_readdata[ST_OP +: 5]     = st.op;
            end
            default:     avs_readdata = '0;
        endcase
    end

    assign program_counter         = st.pc;
    assign global_interrupt_enable = st.sr[SR_GIE];
    assign processor_halt          = st.sr[SR_HALT];
    assign oscillator_stop         = st.sr[SR_OSC];

    // Distance from the jump's own address to the target, in words
    logic signed [PC_W-1:0] span_words;
    assign span_words = $signed(target - st.pc) >>> 1;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_start;
        start;
    endsequence

    sequence s_two_cycles;
        (st.fsm == RJD_EXEC) ##1 (st.fsm == RJD_RETIRE) ##1 (st.fsm == RJD_IDLE);
    endsequence

    jump_target_a: assert property (
        (st.fsm == RJD_RETIRE && is_jump && st.taken) |=> (st.pc == $past(target)))
        else $error("taken jump did not load the computed target");

    jump_reach_a: assert property (
        (st.fsm == RJD_RETIRE && is_jump && st.taken) |-> (span_words >= -511 && span_words <= 512))
        else $error("jump target outside reachable span");

    flags_hold_a: assert property (
        (st.fsm == RJD_EXEC) |=> $stable(st.sr) ##1 $stable(st.sr))
        else $error("status flags changed during a jump");

    zero_branch_a: assert property (
        (st.fsm == RJD_EXEC && is_jump && st.instr[12:11] == 2'b00)
            |=> (st.taken == ($past(st.instr[10]) == st.sr[SR_Z])))
        else $error("zero or nonzero branch decision wrong");

    carry_branch_a: assert property (
        (st.fsm == RJD_EXEC && is_jump && st.instr[12:11] == 2'b01)
            |=> (st.taken == ($past(st.instr[10]) == st.sr[SR_C])))
        else $error("carry or no carry branch decision wrong");

    negative_branch_a: assert property (
        (st.fsm == RJD_EXEC && is_jump && st.instr[12:10] == COND_NEGATIVE) |=> (st.taken == st.sr[SR_N]))
        else $error("negative branch decision wrong");

    signed_branch_a: assert property (
        (st.fsm == RJD_EXEC && is_jump && st.instr[12:10] == COND_LESS) |=> (st.taken == (st.sr[SR_N] ^ st.sr[SR_V])))
        else $error("signed less branch decision wrong");

    always_branch_a: assert property (
        (st.fsm == RJD_EXEC && is_jump && st.instr[12:10] == COND_ALWAYS) |=> ##1 (st.pc == $past(target, 2)))
        else $error("unconditional branch did not load target");

    single_decode_a: assert property (
        (start && avs_writedata[15:6] == 10'h04C) |=> (st.op == OP_RETURN_FROM_INTERRUPT))
        else $error("interrupt return code not decoded");

    double_decode_a: assert property (
        (start && avs_writedata[15:12] == 4'hF) |=> (st.op == OP_AND))
        else $error("top nibble F not decoded as and");

    flag_weights_a: assert property (
        (idle && avs_write && avs_address == ADDR_SR && avs_byteenable[0])
            |=> (st.sr[2:0] == $past(avs_writedata[2:0])))
        else $error("carry zero negative weights misplaced");

    halt_bit_a: assert property (
        (idle && avs_write && avs_address == ADDR_SR && avs_byteenable[0])
            |=> (processor_halt == $past(avs_writedata[4]) && oscillator_stop == $past(avs_writedata[5])))
        else $error("halt or oscillator stop not entered from status write");

    jump_decode_a: assert property (
        (start && avs_writedata[15:13] == JUMP_PREFIX) |=> (st.op == OP_JUMP))
        else $error("jump format not decoded");

    two_cycle_a: assert property (
        s_start |=> s_two_cycles)
        else $error("instruction did not retire in two cycles");

    ge_branch_a: assert property (
        (st.fsm == RJD_EXEC && is_jump && st.instr[12:10] == COND_GE)
            |=> (st.taken == !(st.sr[SR_N] ^ st.sr[SR_V])))
        else $error("signed greater-equal branch decision wrong");

    fall_through_a: assert property (
        (st.fsm == RJD_RETIRE && is_jump && !st.taken) |=> (st.pc == $past(fall_through)))
        else $error("untaken jump did not step one word");

    single_first_a: assert property (
        (start && avs_writedata[15:6] == 10'h040) |=> (st.op == OP_ROTATE_RIGHT_THROUGH_CARRY))
        else $error("first single-operand code not decoded");

    double_first_a: assert property (
        (start && avs_writedata[15:12] == DOUBLE_FIRST) |=> (st.op == OP_MOVE_OP))
        else $error("top nibble 4 not decoded as move");

    gie_bit_a: assert property (
        (idle && avs_write && avs_address == ADDR_SR && avs_byteenable[0])
            |=> (global_interrupt_enable == $past(avs_writedata[3])))
        else $error("interrupt enable not taken from status write");

endmodule

// ### verilog/rjd_pkg.sv
package rjd_pkg;

    localparam int PC_W   = 16;
    localparam int INSN_W = 16;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int OFFS_W = 10;
    localparam int SR_W   = 9;

    // Register byte offsets, one aligned word each
    localparam logic [ADDR_W-1:0] ADDR_INSTR  = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_PC     = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_SR     = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0C;

    // Status register bit positions (weights 1, 2, 4, 8, 10h, 20h, 100h)
    localparam int SR_C    = 0;
    localparam int SR_Z    = 1;
    localparam int SR_N    = 2;
    localparam int SR_GIE  = 3;
    localparam int SR_HALT = 4;
    localparam int SR_OSC  = 5;
    localparam int SR_V    = 8;

    // Status word field positions
    localparam int ST_BUSY  = 0;
    localparam int ST_TAKEN = 1;
    localparam int ST_OP    = 8;

    localparam logic [PC_W-1:0]   PC_RESET   = 16'h0000;
    localparam logic [SR_W-1:0]   SR_RESET   = 9'h000;
    localparam logic [INSN_W-1:0] INSN_RESET = 16'h0000;
    localparam logic [PC_W-1:0]   PC_STEP    = 16'h0002;

    // Opcode space
    localparam logic [2:0] JUMP_PREFIX   = 3'h1;
    localparam logic [5:0] SINGLE_PREFIX = 6'h04;
    localparam logic [4:0] DOUBLE_BASE   = 5'h08;
    localparam logic [3:0] DOUBLE_FIRST  = 4'h4;

    localparam logic [2:0] COND_NONZERO  = 3'h0;
    localparam logic [2:0] COND_ZERO     = 3'h1;
    localparam logic [2:0] COND_NO_CARRY = 3'h2;
    localparam logic [2:0] COND_CARRY    = 3'h3;
    localparam logic [2:0] COND_NEGATIVE = 3'h4;
    localparam logic [2:0] COND_GE       = 3'h5;
    localparam logic [2:0] COND_LESS     = 3'h6;
    localparam logic [2:0] COND_ALWAYS   = 3'h7;

    localparam int JUMP_CYCLES = 2;

    typedef enum logic [4:0] {
        OP_ILLEGAL, OP_ROTATE_RIGHT_THROUGH_CARRY, OP_ROTATE_RIGHT_THROUGH_CARRY_B, OP_BYTE_SWAP,
        OP_ARITHMETIC_RIGHT_SHIFT, OP_ARITHMETIC_RIGHT_SHIFT_B, OP_SIGN_EXTEND, OP_PUSH, OP_PUSH_B,
        OP_CALL, OP_RETURN_FROM_INTERRUPT, OP_JUMP, OP_MOVE_OP, OP_ADD, OP_ADD_WITH_CARRY,
        OP_SUBTRACT_WITH_CARRY, OP_SUB, OP_COMPARE_OP, OP_DECIMAL_ADD, OP_BIT_TEST, OP_BIT_CLEAR,
        OP_BIT_SET, OP_XOR, OP_AND
    } rjd_op_e;

    typedef enum logic [1:0] {
        RJD_IDLE   = 2'b00,
        RJD_EXEC   = 2'b01,
        RJD_RETIRE = 2'b11
    } rjd_fsm_e;

    typedef struct packed {
        logic v;
        logic n;
        logic z;
        logic c;
    } rjd_flags_s;

    typedef struct packed {
        rjd_fsm_e          fsm;
        logic [INSN_W-1:0] instr;
        logic [PC_W-1:0]   pc;
        logic [SR_W-1:0]   sr;
        logic              taken;
        rjd_op_e           op;
    } rjd_state_s;

endpackage

// ### verilog/rjd_target.sv
`timescale 1ns/1ps
module rjd_target
    import rjd_pkg::*;
#(
    parameter int ADDR_BITS = PC_W
)
(
    input  wire logic [ADDR_BITS-1:0] pc_now,
    input  wire logic [OFFS_W-1:0]    offset,
    output logic      [ADDR_BITS-1:0] fall_through,
    output logic      [ADDR_BITS-1:0] target
);

    logic [ADDR_BITS-1:0] byte_offset;

    // Signed word offset becomes a signed byte offset
    assign byte_offset  = {{(ADDR_BITS-OFFS_W-1){offset[OFFS_W-1]}}, offset, 1'b0};
    assign fall_through = pc_now + ADDR_BITS'(PC_STEP);
    // Wraps modulo the address space, as the counter does
    assign target       = fall_through + byte_offset;

endmodule
